// *** verilog/dmacc_regs.vh ***
// Purpose: register map and reset values for the dma channel address/count/collision block
// Assumes: avalon-mm word addressing, 32-bit data, 16-bit registers in low bits
// Notes:   included by all design files
//
// Contract
// R1: each channel has a 16-bit read/write peripheral address register cleared at reset.
// R2: each channel has a 14-bit read/write transfer count in bits 13..0, upper two bits read zero.
// R3: a channel performs one more transfer than its programmed count, so zero means one transfer.
// R4: software must not write address or count of a channel while it is enabled and active.
// R5: a read-only flag per channel 0..3 in bits 0..3 reads one after a peripheral write collision; the code sets it only while the channel is enabled.
// R6: bits 15..4 of the collision status read zero and all four flags reset to zero.
// R7: a collision flag sets when a dma write to the peripheral address meets another master's write; the code sets it only while the channel is enabled.
`ifndef DMACC_REGS_VH
`define DMACC_REGS_VH

// --------------------------------------------------------------
// word addresses
// --------------------------------------------------------------
`define DMACC_ADDR_W        6
`define DMACC_OFS_CTRL      6'h00
`define DMACC_OFS_STAT      6'h01
`define DMACC_OFS_COL       6'h02
`define DMACC_OFS_IRQ_STAT  6'h03
`define DMACC_OFS_IRQ_MASK  6'h04
`define DMACC_OFS_CH_BASE   6'h08
`define DMACC_CH_STRIDE     6'h02
`define DMACC_CH_PAD        1'b0
`define DMACC_CH_CNT        1'b1

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define DMACC_CNT_W         14
`define DMACC_PAD_W         16
`define DMACC_PAD_RST       16'h0000
`define DMACC_CNT_RST       14'h0000
`define DMACC_COL_CH        4
`define DMACC_IRQ_DONE_POS  0
`define DMACC_IRQ_COL_POS   4

`endif

// *** verilog/dmacc_xfer_counter.v ***
// Purpose: per-channel transfer counter
// Assumes: start is a one-cycle pulse, beat marks one completed transfer
// Notes:   loads programmed count and runs count+1 beats
`timescale 1ns/1ps
`include "dmacc_regs.vh"

module dmacc_xfer_counter #(
  parameter CW = `DMACC_CNT_W
) (
  input  wire          clk,     // system clock
  input  wire          reset,   // sync reset, active high
  input  wire          start,   // begin a block
  input  wire [CW-1:0] count,   // programmed count
  input  wire          beat,    // one transfer done
  output reg           active,  // block in progress
  output reg           done     // pulse after last transfer
);

  reg [CW-1:0] left_q;

  // ------------------------------------------------------------
  // remaining-transfer counter
  // ------------------------------------------------------------
  // counting down to zero inclusive gives count+1 beats
  always @(posedge clk)
  begin
    done <= 1'b0;
    if (reset)
    begin
      left_q <= {CW{1'b0}};
      active <= 1'b0;
    end
    else if (start && !active)
    begin
      left_q <= count;
      active <= 1'b1;
    end
    else if (active && beat)
    begin
      if (left_q == {CW{1'b0}})         // [R3]
      begin
        active <= 1'b0;
        done   <= 1'b1;
      end
      else
        left_q <= left_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule // dmacc_xfer_counter

// *** verilog/dmacc_collide.v ***
// Purpose: peripheral write collision detector for one channel
// Assumes: both write strobes are on clk
// Notes:   registered compare, flag storage is in the top
`timescale 1ns/1ps
`include "dmacc_regs.vh"

module dmacc_collide #(
  parameter AW = `DMACC_PAD_W
) (
  input  wire          clk,        // system clock
  input  wire          reset,      // sync reset, active high
  input  wire          dma_wr,     // this channel writes peripheral
  input  wire [AW-1:0] dma_addr,   // its peripheral address
  input  wire          other_wr,   // other master writes
  input  wire [AW-1:0] other_addr, // other master address
  output reg           hit         // registered one-cycle collision
);

  // ------------------------------------------------------------
  // same-cycle same-address compare
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
      hit <= 1'b0;
    else
      hit <= dma_wr && other_wr && (dma_addr == other_addr); // [R7]
  end

endmodule // dmacc_collide

// *** verilog/dmacc_top.v ***
// Purpose: dma channel address, count and collision status with avalon-mm slave
// Assumes: one clock, sync reset; peripheral writes are driven by the channel engine
// Notes:   registers answer with one wait state
`timescale 1ns/1ps
`include "dmacc_regs.vh"

module dmacc_top #(
  parameter NCH = `DMACC_COL_CH
) (
  input  wire                     clk,            // 10 mhz system clock
  input  wire                     reset,          // sync reset, active high
  input  wire [`DMACC_ADDR_W-1:0] address,        // word address
  input  wire                     read,           // read request
  input  wire                     write,          // write request
  input  wire [3:0]               byteenable,     // byte lanes
  input  wire [31:0]              writedata,      // write data
  output reg  [31:0]              readdata,       // read data
  output wire                     waitrequest,    // stall
  input  wire [NCH-1:0]           beat,           // per channel transfer done
  input  wire [NCH-1:0]           other_wr,       // other master write, per channel port
  input  wire [16*NCH-1:0]        other_addr,     // other master address per channel
  output wire [NCH-1:0]           periph_wr,      // dma peripheral write strobe
  output reg  [16*NCH-1:0]        periph_addr,    // peripheral address out
  output wire [NCH-1:0]           ch_active,      // channel busy
  output wire                     irq             // level interrupt
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [15:0]      pad_q [0:NCH-1];
  reg  [13:0]      cnt_q [0:NCH-1];
  reg  [NCH-1:0]   en_q;
  reg  [NCH-1:0]   col_q;
  reg  [NCH-1:0]   start_q;
  reg  [7:0]       ist_q;
  reg  [7:0]       imask_q;
  reg              ack_q;
  wire [NCH-1:0]   done;
  wire [NCH-1:0]   hit;
  wire             acc;
  wire             wr_go;
  wire             rd_go;

  // one wait state per access, then release
  assign acc         = (read || write) && !ack_q;
  assign waitrequest = acc;
  assign wr_go       = write && ack_q;
  assign rd_go       = read && ack_q;

  // word index decode for channel registers
  function is_ch;
    input [`DMACC_ADDR_W-1:0] a;
    input integer             ch;
    input                     sel;
    begin
      is_ch = (a == (`DMACC_OFS_CH_BASE + ch[`DMACC_ADDR_W-1:0] * `DMACC_CH_STRIDE
                     + {{(`DMACC_ADDR_W-1){1'b0}}, sel}));
    end
  endfunction

  // ------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
      ack_q <= 1'b0;
    else
      ack_q <= acc;
  end

  // ------------------------------------------------------------
  // per-channel registers and sub-blocks
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      // software writes land regardless; writing while active is the user's hazard
      always @(posedge clk)
      begin
        if (reset)
        begin
          pad_q[g] <= `DMACC_PAD_RST;                 // [R1]
          cnt_q[g] <= `DMACC_CNT_RST;                 // [R2]
        end
        else if (wr_go)
        begin
          if (is_ch(address, g, `DMACC_CH_PAD))
          begin
            if (byteenable[0]) pad_q[g][7:0]  <= writedata[7:0];  // [R1]
            if (byteenable[1]) pad_q[g][15:8] <= writedata[15:8];
          end
          if (is_ch(address, g, `DMACC_CH_CNT))
          begin
            if (byteenable[0]) cnt_q[g][7:0]  <= writedata[7:0];  // [R2]
            if (byteenable[1]) cnt_q[g][13:8] <= writedata[13:8];
          end
        end
      end

      // address out registered so its view of pad is stable per cycle
      always @(posedge clk)
      begin
        if (reset)
          periph_addr[16*g +: 16] <= 16'h0000;
        else
          periph_addr[16*g +: 16] <= pad_q[g];
      end

      dmacc_xfer_counter #(.CW(`DMACC_CNT_W)) u_cnt (
        .clk    (clk),
        .reset  (reset),
        .start  (start_q[g]),
        .count  (cnt_q[g]),
        .beat   (beat[g]),
        .active (ch_active[g]),
        .done   (done[g])
      );

      assign periph_wr[g] = ch_active[g] && beat[g];

      dmacc_collide #(.AW(16)) u_col (
        .clk        (clk),
        .reset      (reset),
        .dma_wr     (periph_wr[g]),
        .dma_addr   (periph_addr[16*g +: 16]),
        .other_wr   (other_wr[g]),
        .other_addr (other_addr[16*g +: 16]),
        .hit        (hit[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // control: enable bits and start pulses
  // ------------------------------------------------------------
  // writing ones to ctrl bits n and n+4 in the same write starts channel n
  always @(posedge clk)
  begin
    if (reset)
    begin
      en_q    <= {NCH{1'b0}};
      start_q <= {NCH{1'b0}};
    end
    else
    begin
      start_q <= {NCH{1'b0}};
      if (wr_go && address == `DMACC_OFS_CTRL && byteenable[0])
      begin
        en_q    <= writedata[NCH-1:0];
        start_q <= writedata[NCH+3:4] & writedata[NCH-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // collision flags: sticky, read-only, cleared only by reset
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
      col_q <= {NCH{1'b0}};                         // [R6]
    else
      col_q <= col_q | (hit & en_q);                // [R5] [R7]
  end

  // ------------------------------------------------------------
  // interrupt status: read clears, new event wins
  // ------------------------------------------------------------
  // only bits captured into readdata are cleared, so an event landing
  // between capture and release is kept for the next read
  always @(posedge clk)
  begin
    if (reset)
    begin
      ist_q   <= 8'h00;
      imask_q <= 8'h00;
    end
    else
    begin
      if (wr_go && address == `DMACC_OFS_IRQ_MASK && byteenable[0])
        imask_q <= writedata[7:0];
      ist_q <= ((rd_go && address == `DMACC_OFS_IRQ_STAT) ? (ist_q & ~readdata[7:0]) : ist_q)
               | {hit, done};
    end
  end

  assign irq = |(ist_q & imask_q);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // data registered at the wait cycle so it stands at the release edge
  integer i;
  always @(posedge clk)
  begin
    if (reset)
    begin
      readdata <= 32'h0000_0000;
    end
    else
    begin
      if (read && !ack_q)
      begin
        readdata <= 32'h0000_0000;
        case (address)
          `DMACC_OFS_CTRL:     readdata <= {28'h0000000, en_q};
          `DMACC_OFS_STAT:     readdata <= {28'h0000000, ch_active};
          `DMACC_OFS_COL:      readdata <= {28'h0000000, col_q};   // [R5] [R6]
          `DMACC_OFS_IRQ_STAT: readdata <= {24'h000000, ist_q};
          `DMACC_OFS_IRQ_MASK: readdata <= {24'h000000, imask_q};
          default:
          begin
            for (i = 0; i < NCH; i = i + 1)
            begin
              if (is_ch(address, i, `DMACC_CH_PAD))
                readdata <= {16'h0000, pad_q[i]};
              if (is_ch(address, i, `DMACC_CH_CNT))
                readdata <= {18'h00000, cnt_q[i]};             // [R2]
            end
          end
        endcase
      end
    end
  end

endmodule // dmacc_top

// *** testbench/dmacc_periph_model.sv ***
// Purpose: peripheral side model, makes beats and other master writes
// Assumes: one clock, beats only for busy channels
// Notes:   released address lines show the inverse of their last value
`timescale 1ns/1ps
module dmacc_periph_model (
  input  wire [3:0]   ch_active,   // busy channels
  input  wire [63:0]  periph_addr, // dma target addresses
  input  wire         clk,         // system clock
  input  wire         reset,       // sync reset
  input  wire         slow,        // beat every 4th cycle
  input  wire [3:0]   collide,     // mirror dma address
  input  wire [3:0]   foreign,     // hit a different address
  output logic [3:0]  beat,        // transfer done
  output logic [3:0]  other_wr,    // other master strobe
  output logic [63:0] other_addr   // other master address
);
  logic   [1:0] ph_q;
  logic         go;
  integer       i;
  // -----------------------------------------------
  // beat pacing, never back to back, so no beat is lost at the end
  // -----------------------------------------------
  always @(posedge clk)
  begin
    ph_q <= reset ? 2'h0 : ph_q + 2'h1;
    for (i = 0; i < 4; i = i + 1)
    begin
      go = !reset && ch_active[i] && (slow ? ph_q == 2'h3 : ph_q[0]);
      beat[i] <= go;
      other_wr[i] <= go && (collide[i] || foreign[i]);
      if (go && collide[i])
        other_addr[16*i +: 16] <= periph_addr[16*i +: 16];
      else if (go && foreign[i])
        other_addr[16*i +: 16] <= periph_addr[16*i +: 16] ^ 16'h0001;
      else
        other_addr[16*i +: 16] <= ~other_addr[16*i +: 16];
    end
  end
endmodule // dmacc_periph_model

// *** testbench/dmacc_top_monitor.sv ***
// Purpose: port assertions for dmacc_top
// Assumes: one clock, sync reset
// Notes:   bound to every dmacc_top
`timescale 1ns/1ps
`include "dmacc_regs.vh"
module dmacc_top_monitor #(
  parameter NCH = 4
) (
  input wire                     clk,         // clock
  input wire                     reset,       // sync reset
  input wire [`DMACC_ADDR_W-1:0] address,     // word address
  input wire                     read,        // read
  input wire                     write,       // write
  input wire [31:0]              readdata,    // read data
  input wire                     waitrequest, // stall
  input wire [NCH-1:0]           beat,        // transfer done
  input wire [NCH-1:0]           periph_wr,   // dma write
  input wire [NCH-1:0]           ch_active,   // busy
  input wire                     irq          // interrupt
);
  // -----------------------------------------------
  // checks
  // -----------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // an answered read, readdata stands in this cycle
  wire rd_ok = read && !waitrequest;
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state not one cycle");
  AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest)
    else $error("request answered without wait");
  AST_PWR: assert property (periph_wr == (ch_active & beat))
    else $error("peripheral write without active beat");
  AST_ACT_FALL: assert property ((($past(ch_active) & ~ch_active & ~$past(beat)) == 0))
    else $error("channel went idle without a final transfer");
  AST_PAD_HI: assert property (rd_ok && address >= 8 && !address[0] |-> !readdata[31:16])
    else $error("address read upper bits set");
  AST_CNT_HI: assert property (rd_ok && address >= 8 && address[0] |-> !readdata[31:14])
    else $error("count read bits above 13 set");
  AST_COL_HI: assert property (rd_ok && address == `DMACC_OFS_COL |-> !readdata[31:4])
    else $error("collision read bits above 3 set");
  AST_IRQ_RST: assert property (disable iff (1'b0) reset |=> !irq)
    else $error("irq high after reset");
  AST_ACT_RST: assert property (disable iff (1'b0) reset |=> ch_active == 0)
    else $error("channel busy after reset");
endmodule // dmacc_top_monitor
bind dmacc_top dmacc_top_monitor #(.NCH(NCH)) u_mon (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .beat(beat),
  .periph_wr(periph_wr), .ch_active(ch_active), .irq(irq)
);

// *** testbench/tb_dma_channel_addr_count_collision.sv ***
// Purpose: self-checking bench for dmacc_top
// Assumes: one wait state bus, partner model on the peripheral side
// Notes:   prints only mismatches and the verdict
`timescale 1ns/1ps
`include "dmacc_regs.vh"
module tb_dma_channel_addr_count_collision;
  logic        clk, reset, read, write, slow;
  logic [5:0]  address;
  logic [31:0] writedata, rd;
  logic [3:0]  byteenable, collide, foreign;
  wire  [31:0] readdata;
  wire  [3:0]  beat, other_wr, periph_wr, ch_active;
  wire  [63:0] other_addr, periph_addr;
  wire         waitrequest, irq;
  integer      errors, checks_done, n, k;
  integer      cyc = 0;
  dmacc_top u_dut (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .beat(beat),
    .other_wr(other_wr), .other_addr(other_addr), .periph_wr(periph_wr),
    .periph_addr(periph_addr), .ch_active(ch_active), .irq(irq));
  dmacc_periph_model u_per (.clk(clk), .reset(reset), .ch_active(ch_active),
    .periph_addr(periph_addr), .slow(slow), .collide(collide),
    .foreign(foreign), .beat(beat), .other_wr(other_wr), .other_addr(other_addr));
  // -----------------------------------------------
  // clock and hang guard
  // -----------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  // -----------------------------------------------
  // shared tasks
  // -----------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // start channels in m, count dma writes of channel c until all idle
  task run(input logic [3:0] m, input integer c);
    n = 0;
    bus(1, `DMACC_OFS_CTRL, {24'h0, m, m});
    repeat (3) @(posedge clk);
    chk("ch_active", {28'h0, m}, {28'h0, ch_active});
    while (ch_active !== 4'h0)
    begin
      if (periph_wr[c] === 1'b1)
        n = n + 1;
      @(posedge clk);
    end
    bus(1, `DMACC_OFS_CTRL, 32'h0); // disabled before any reprogramming
  endtask
  // -----------------------------------------------
  // scenarios
  // -----------------------------------------------
  task t_reset;
    for (k = 8; k < 16; k = k + 1)
    begin
      bus(0, k[5:0], 32'h0);
      chk("chan reg reset", 32'h0, rd);
    end
    bus(0, `DMACC_OFS_COL, 32'h0);
    chk("col reset", 32'h0, rd);
  endtask
  task t_regs;
    for (k = 0; k < 4; k = k + 1)
    begin
      bus(1, 6'h08 + 2 * k, 32'hffff_a5c0 + k);
      bus(1, 6'h09 + 2 * k, 32'hffff_ffff);
      bus(0, 6'h08 + 2 * k, 32'h0);
      chk("pad", 32'ha5c0 + k, rd);
      bus(0, 6'h09 + 2 * k, 32'h0);
      chk("cnt", 32'h3fff, rd);
    end
    bus(1, `DMACC_OFS_COL, 32'hffff_ffff);
    bus(0, `DMACC_OFS_COL, 32'h0);
    chk("col write", 32'h0, rd);
    bus(1, 6'h3f, 32'hffff_ffff);
    bus(0, 6'h3f, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1, `DMACC_OFS_CTRL, 32'h0000_000f);
    bus(0, `DMACC_OFS_CTRL, 32'h0);
    chk("ctrl", 32'hf, rd);
    bus(0, `DMACC_OFS_STAT, 32'h0);
    chk("stat idle", 32'h0, rd);
    bus(1, `DMACC_OFS_CTRL, 32'h0);
    bus(1, `DMACC_OFS_IRQ_MASK, 32'h0000_00a5);
    bus(0, `DMACC_OFS_IRQ_MASK, 32'h0);
    chk("irq_mask", 32'ha5, rd);
  endtask
  task t_count;
    for (k = 0; k < 2; k = k + 1)
    begin
      slow <= k[0];
      bus(1, `DMACC_OFS_IRQ_MASK, {30'h0, k[0], 1'b0});
      bus(1, 6'h0b, 32'h5 * k);
      run(4'h2, 1);
      chk("beats", 32'h1 + 32'h5 * k, n);
      chk("irq", {31'h0, k[0]}, {31'h0, irq});
      bus(0, `DMACC_OFS_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h2, rd);
      @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
  endtask
  task t_collide;
    bus(1, 6'h0c, 32'h1234);
    bus(1, 6'h0e, 32'h1234);
    bus(1, 6'h0d, 32'h3);
    bus(1, 6'h0f, 32'h3);
    slow <= 1'b0;
    collide <= 4'h4;
    foreign <= 4'h8;
    run(4'hc, 2);
    chk("beats ch2", 32'h4, n);
    chk("periph_addr ch2", 32'h1234, {16'h0, periph_addr[47:32]});
    bus(0, `DMACC_OFS_COL, 32'h0);
    chk("col flags", 32'h4, rd);
    bus(0, `DMACC_OFS_COL, 32'h0);
    chk("col sticky", 32'h4, rd);
    bus(0, `DMACC_OFS_IRQ_STAT, 32'h0);
    chk("irq_stat col", 32'h4c, rd);
  endtask
  task print_verdict;
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial
  begin
    errors = 0;
    checks_done = 0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'h3;
    slow = 1'b0;
    collide = 4'h0;
    foreign = 4'h0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_regs;
    t_count;
    t_collide;
    print_verdict;
  end
endmodule // tb_dma_channel_addr_count_collision
